/* File: rar_pkg.sv */
// Constants and types for the I2C alias remap block
package rar_pkg;

  // Slot geometry
  localparam int          NSLOT  = 8;
  localparam int          SLOT_W = 3;
  localparam logic [7:0]  NSLOT_IDX = 8'h08;

  // APB geometry
  localparam int          AW     = 12;
  localparam int          DW     = 32;
  localparam int          IDX_HI = 9;
  localparam int          IDX_LO = 2;
  localparam int          TOP_HI = 11;
  localparam int          TOP_LO = 10;

  // Register indexes; byte address is four times the index
  localparam logic [7:0]  REMOTE_ADDR_SLOT5_IDX = 8'h3E;
  localparam logic [7:0]  REMOTE_ADDR_SLOT6_IDX = 8'h3F;
  localparam logic [7:0]  REMOTE_ADDR_SLOT7_IDX = 8'h40;
  localparam logic [7:0]  MATCH_ADDR_SLOT0_IDX  = 8'h41;
  localparam logic [7:0]  MATCH_ADDR_SLOT1_IDX  = 8'h42;
  localparam logic [7:0]  MATCH_ADDR_SLOT2_IDX  = 8'h43;
  localparam logic [7:0]  MATCH_ADDR_SLOT3_IDX  = 8'h44;
  localparam logic [7:0]  PHYS_BASE_IDX  = REMOTE_ADDR_SLOT5_IDX - 8'h05;
  localparam logic [7:0]  ALIAS_BASE_IDX = MATCH_ADDR_SLOT0_IDX;

  // Field layout of both register kinds
  localparam int          FLD_HI  = 7;
  localparam int          FLD_LO  = 1;
  localparam int          ACK_BIT = 0;
  localparam logic [7:0]  CFG_RESET = 8'h00;
  localparam logic [6:0]  ADDR_NONE = 7'h00;

  // Local I2C request as seen by the remapper
  typedef struct packed {
    logic [6:0] addr;
    logic       wr;
  } rar_i2c_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FWD  = 2'h1,
    ST_WAIT = 2'h3,
    ST_RESP = 2'h2
  } rar_state_t;

endpackage

/* File: rar_alias_remap.sv */
// I2C alias match and remap slots with APB register access
`timescale 1ns/1ps
// Behaviour
// RULE_01: Each slot holds a 7-bit physical address in bits 7:1; bit 0 reads zero.
// RULE_02: A request hitting an alias is forwarded with the physical address instead. The code forwards only while i_fwd_lock is high.
// RULE_03: Each slot has a 7-bit alias in bits 7:1 used to match requests.
// RULE_04: Alias of slot N maps to physical address of slot N.
// RULE_05: A zero alias disables its slot; nothing is matched or forwarded through it.
// RULE_06: Alias bit 0 is a read/write forced-acknowledge enable per slot.
// RULE_07: Forced acknowledge answers writes ignoring link lock and remote acknowledge.
// RULE_08: Software uses forced acknowledge only for debugging.
// RULE_09: After reset all address fields and forced-acknowledge bits are zero.
// RULE_10: A request matching no nonzero alias is not forwarded.
module rar_alias_remap (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  // APB slave
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [rar_pkg::AW-1:0]     i_paddr,
  input  wire logic [rar_pkg::DW-1:0]     i_pwdata,
  output logic      [rar_pkg::DW-1:0]     o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  // Local I2C controller side
  input  wire logic                       i_req_valid,
  input  wire rar_pkg::rar_i2c_req_t      i_req,
  output logic                            o_req_ready,
  output logic                            o_rsp_valid,
  output logic                            o_rsp_ack,
  // Control channel to the remote side
  input  wire logic                       i_fwd_lock,
  output logic                            o_fwd_valid,
  output rar_pkg::rar_i2c_req_t           o_fwd,
  input  wire logic                       i_fwd_ready,
  input  wire logic                       i_remote_done,
  input  wire logic                       i_remote_ack
);

  localparam int SLOT_W = rar_pkg::SLOT_W;
  localparam int NSLOT  = rar_pkg::NSLOT;

  ////////////////////////////////////////////////////////////////////////////
  // Register address decode

  function automatic logic [SLOT_W:0] slot_dec(
    input logic [rar_pkg::AW-1:0] a,
    input logic [7:0]             base
  );
    logic [7:0] off;
    off = a[rar_pkg::IDX_HI:rar_pkg::IDX_LO] - base;
    slot_dec = {(a[1:0] == 2'h0) &&
                (a[rar_pkg::TOP_HI:rar_pkg::TOP_LO] == 2'h0) &&
                (off < rar_pkg::NSLOT_IDX), off[SLOT_W-1:0]};
  endfunction

  logic [7:0]             phys_reg  [NSLOT];
  logic [7:0]             alias_reg [NSLOT];
  logic [rar_pkg::DW-1:0] prdata_reg;

  wire logic [SLOT_W:0]   phys_d   = slot_dec(i_paddr, rar_pkg::PHYS_BASE_IDX);
  wire logic [SLOT_W:0]   alias_d  = slot_dec(i_paddr,
                                              rar_pkg::ALIAS_BASE_IDX);
  wire logic              phys_ok  = phys_d[SLOT_W];
  wire logic              alias_ok = alias_d[SLOT_W];
  wire logic [SLOT_W-1:0] p_slot   = phys_d[SLOT_W-1:0];
  wire logic [SLOT_W-1:0] a_slot   = alias_d[SLOT_W-1:0];
  wire logic              apb_set  = i_psel && !i_penable;
  wire logic              apb_acc  = i_psel && i_penable;
  wire logic              apb_wr   = apb_acc && i_pwrite;
  wire logic              phys_we  = apb_wr && phys_ok;
  wire logic              alias_we = apb_wr && alias_ok;
  wire logic [7:0]        rd_byte  = phys_ok  ? phys_reg[p_slot]  :
                                     alias_ok ? alias_reg[a_slot] :
                                                rar_pkg::CFG_RESET;

  // Zero wait states; read data is captured in the setup cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !(phys_ok || alias_ok);
  assign o_prdata  = prdata_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prdata_reg <= '0;
    end else if (apb_set && !i_pwrite) begin
      prdata_reg <= {24'h000000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot storage and alias match

  logic [NSLOT-1:0] slot_hit;

  for (genvar n = 0; n < NSLOT; n++) begin : g_slot
    localparam logic [SLOT_W-1:0] SLOT_ID = SLOT_W'(n);
    wire logic [6:0] alias_f = alias_reg[n][rar_pkg::FLD_HI:rar_pkg::FLD_LO];

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        phys_reg[n]  <= rar_pkg::CFG_RESET;                       // RULE_09
        alias_reg[n] <= rar_pkg::CFG_RESET;                       // RULE_09
      end else begin
        if (phys_we && p_slot == SLOT_ID) begin
          // Bit 0 is reserved and never stored
          phys_reg[n] <= {i_pwdata[rar_pkg::FLD_HI:rar_pkg::FLD_LO],
                          1'b0};                                  // RULE_01
        end
        if (alias_we && a_slot == SLOT_ID) begin
          alias_reg[n] <= i_pwdata[rar_pkg::FLD_HI:0];            // RULE_06
        end
      end
    end

    // Zero alias never matches, even a general call address
    assign slot_hit[n] = (alias_f != rar_pkg::ADDR_NONE) &&
                         (alias_f == i_req.addr);          // RULE_03 RULE_05
  end

  // Lowest slot wins when two aliases are equal
  logic              hit_any;
  logic [SLOT_W-1:0] hit_idx;

  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int k = NSLOT - 1; k >= 0; k--) begin
      if (slot_hit[k]) begin
        hit_any = 1'b1;                                           // RULE_10
        hit_idx = SLOT_W'(k);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer

  rar_pkg::rar_state_t   state_reg;
  rar_pkg::rar_state_t   state_next;
  rar_pkg::rar_i2c_req_t fwd_reg;
  logic                  force_reg;
  logic                  ack_reg;
  logic                  ack_next;
  logic [SLOT_W-1:0]     slot_reg;

  wire logic req_take  = i_req_valid && state_reg == rar_pkg::ST_IDLE;
  wire logic req_force = alias_reg[hit_idx][rar_pkg::ACK_BIT] && i_req.wr;
  wire logic fwd_take  = o_fwd_valid && i_fwd_ready;

  assign o_req_ready = state_reg == rar_pkg::ST_IDLE;
  assign o_fwd_valid = state_reg == rar_pkg::ST_FWD;
  assign o_rsp_valid = state_reg == rar_pkg::ST_RESP;
  assign o_fwd       = fwd_reg;
  assign o_rsp_ack   = ack_reg;

  always_comb begin
    state_next = state_reg;
    ack_next   = ack_reg;
    unique case (state_reg)
      rar_pkg::ST_IDLE: begin
        if (req_take) begin
          if (!hit_any) begin
            state_next = rar_pkg::ST_RESP;                        // RULE_10
            ack_next   = 1'b0;
          end else if (i_fwd_lock) begin
            state_next = rar_pkg::ST_FWD;                         // RULE_02
            ack_next   = 1'b0;
          end else begin
            state_next = rar_pkg::ST_RESP;
            ack_next   = req_force;                               // RULE_07
          end
        end
      end
      rar_pkg::ST_FWD: begin
        // Forced writes do not wait for the remote answer
        if (!i_fwd_lock) begin
          state_next = rar_pkg::ST_RESP;
          ack_next   = force_reg;                                 // RULE_07
        end else if (fwd_take) begin
          state_next = force_reg ? rar_pkg::ST_RESP : rar_pkg::ST_WAIT;
          ack_next   = force_reg;                                 // RULE_07
        end
      end
      rar_pkg::ST_WAIT: begin
        // Losing lock ends the wait rather than hanging the bus
        if (!i_fwd_lock) begin
          state_next = rar_pkg::ST_RESP;
          ack_next   = 1'b0;
        end else if (i_remote_done) begin
          state_next = rar_pkg::ST_RESP;
          ack_next   = i_remote_ack;
        end
      end
      rar_pkg::ST_RESP: begin
        state_next = rar_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= rar_pkg::ST_IDLE;
      ack_reg   <= 1'b0;
      force_reg <= 1'b0;
      slot_reg  <= '0;
      fwd_reg   <= '0;
    end else begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
      if (req_take) begin
        force_reg <= hit_any && req_force;                        // RULE_06
        slot_reg  <= hit_idx;
        fwd_reg   <= '{addr: phys_reg[hit_idx][rar_pkg::FLD_HI:
                                               rar_pkg::FLD_LO],
                       wr:   i_req.wr};                    // RULE_02 RULE_04
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  wire logic [7:0] hit_phys  = phys_reg[slot_reg];
  wire logic [7:0] hit_alias = alias_reg[slot_reg];
  logic            any_cfg;

  always_comb begin
    any_cfg = 1'b0;
    for (int k = 0; k < NSLOT; k++) begin
      any_cfg = any_cfg || (phys_reg[k] != rar_pkg::CFG_RESET) ||
                (alias_reg[k] != rar_pkg::CFG_RESET);
    end
  end

  AST_PHYS_RD_BIT0: assert property (                       // RULE_01
    apb_set && !i_pwrite && phys_ok |=> o_prdata[rar_pkg::ACK_BIT] == 1'b0)
    else $error("physical address read shows bit 0 set");

  AST_PHYS_WRITE: assert property (                         // RULE_01
    phys_we |=> phys_reg[$past(p_slot)] ==
      {$past(i_pwdata[rar_pkg::FLD_HI:rar_pkg::FLD_LO]), 1'b0})
    else $error("physical address write not stored");

  AST_ALIAS_WRITE: assert property (                        // RULE_06
    alias_we |=> alias_reg[$past(a_slot)] ==
      $past(i_pwdata[rar_pkg::FLD_HI:0]))
    else $error("alias write not stored");

  AST_FWD_REMAP: assert property (                          // RULE_04
    o_fwd_valid |-> o_fwd.addr == hit_phys[rar_pkg::FLD_HI:rar_pkg::FLD_LO]
      || $changed(hit_phys) || $past(phys_we))
    else $error("forwarded address is not the paired physical address");

  AST_FWD_ON_HIT: assert property (                         // RULE_02
    req_take && hit_any && i_fwd_lock |=> o_fwd_valid ##0
      o_fwd.addr == $past(phys_reg[hit_idx][rar_pkg::FLD_HI:
                                            rar_pkg::FLD_LO]))
    else $error("matched request not forwarded with physical address");

  AST_NO_FWD_DISABLED: assert property (                    // RULE_05
    $rose(o_fwd_valid) |-> $past(alias_reg[hit_idx][rar_pkg::FLD_HI:
      rar_pkg::FLD_LO]) != rar_pkg::ADDR_NONE)
    else $error("forward through a disabled slot");

  AST_MISS_NACK: assert property (                          // RULE_10
    req_take && !hit_any |=> o_rsp_valid && !o_rsp_ack ##1 o_req_ready)
    else $error("unmatched request was not refused");

  AST_FORCE_NOLOCK: assert property (                       // RULE_07
    req_take && hit_any && req_force && !i_fwd_lock |=> o_rsp_valid &&
      o_rsp_ack)
    else $error("forced write not acknowledged without lock");

  AST_FORCE_FWD: assert property (                          // RULE_07
    o_fwd_valid && force_reg && i_fwd_ready |=> o_rsp_valid && o_rsp_ack)
    else $error("forced write waited for the remote answer");

  AST_LOCK_LOST: assert property (                          // RULE_07
    o_fwd_valid && !i_fwd_lock |=> o_rsp_valid &&
      o_rsp_ack == $past(force_reg))
    else $error("lost lock did not end the forward correctly");

  AST_REMOTE_ACK: assert property (                         // RULE_02
    state_reg == rar_pkg::ST_WAIT && i_fwd_lock && i_remote_done |=>
      o_rsp_valid && o_rsp_ack == $past(i_remote_ack))
    else $error("remote answer not passed back");

  AST_RESET_CLEAR: assert property (                        // RULE_09
    $past(i_srst) |-> !any_cfg && o_req_ready && !o_fwd_valid)
    else $error("configuration not cleared by reset");

  AST_RSP_PULSE: assert property (
    o_rsp_valid |=> !o_rsp_valid && o_req_ready)
    else $error("response longer than one cycle");

  COV_HIT_FWD:   cover property (req_take && hit_any && i_fwd_lock);
  COV_MISS:      cover property (req_take && !hit_any);
  COV_FORCED:    cover property (o_fwd_valid && force_reg && i_fwd_ready);
  COV_REMOTE_OK: cover property (state_reg == rar_pkg::ST_WAIT &&
                                 i_remote_done && i_remote_ack);

endmodule

/* File: rar_remote_model.sv */
// Remote side model answering forwarded requests
`timescale 1ns/1ps
module rar_remote_model (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Forward channel
  input  wire logic i_fwd_valid,
  output logic      o_fwd_ready,
  output logic      o_done,
  output logic      o_ack,
  // Behaviour chosen by the bench
  input  wire logic i_slow,
  input  wire logic i_ack
);
  logic [2:0] cnt_reg;
  logic       busy_reg;
  logic       tog_reg;
  wire  [2:0] dly = i_slow ? 3'h5 : 3'h0;
  // Ack line carries junk outside the done pulse
  assign o_ack = o_done ? i_ack : tog_reg;
  always_ff @(posedge i_clk) begin
    tog_reg     <= i_srst ? 1'b0 : ~tog_reg;
    o_fwd_ready <= 1'b0;
    o_done      <= 1'b0;
    if (i_srst) begin
      cnt_reg  <= 3'h0;
      busy_reg <= 1'b0;
    end else if ((i_fwd_valid || busy_reg) && cnt_reg != dly) begin
      cnt_reg <= cnt_reg + 3'h1;
    end else if (busy_reg) begin
      o_done   <= 1'b1;
      busy_reg <= 1'b0;
      cnt_reg  <= 3'h0;
    end else if (i_fwd_valid && !o_fwd_ready) begin
      o_fwd_ready <= 1'b1;
      busy_reg    <= 1'b1;
      cnt_reg     <= 3'h0;
    end
  end
endmodule

/* File: rar_alias_remap_bench.sv */
// Self-checking bench for the I2C alias remap block
`timescale 1ns/1ps
module rar_alias_remap_bench;
  logic                  i_clk = 1'b0;
  logic                  i_srst = 1'b1;
  logic                  i_psel = 1'b0;
  logic                  i_penable = 1'b0;
  logic                  i_pwrite = 1'b0;
  logic [11:0]           i_paddr = 12'h000;
  logic [31:0]           i_pwdata = 32'h0;
  logic [31:0]           o_prdata;
  logic                  o_pready;
  logic                  o_pslverr;
  logic                  i_req_valid = 1'b0;
  rar_pkg::rar_i2c_req_t i_req = '0;
  logic                  o_req_ready;
  logic                  o_rsp_valid;
  logic                  o_rsp_ack;
  logic                  i_fwd_lock = 1'b0;
  logic                  o_fwd_valid;
  rar_pkg::rar_i2c_req_t o_fwd;
  logic                  i_fwd_ready;
  logic                  i_remote_done;
  logic                  i_remote_ack;
  logic                  slow = 1'b0;
  logic                  mack = 1'b0;
  logic [7:0]            mdl [2][8];
  logic [33:0]           q_apb [$], q_rsp [$], q_fwd [$];
  logic [33:0]           e;
  logic [6:0]            old;
  int                    errors = 0;
  int                    compares = 0;
  int                    cyc = 0;

  rar_alias_remap rar_alias_remap_i (.i_clk, .i_srst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_req_valid, .i_req, .o_req_ready, .o_rsp_valid, .o_rsp_ack,
    .i_fwd_lock, .o_fwd_valid, .o_fwd, .i_fwd_ready, .i_remote_done,
    .i_remote_ack);
  rar_remote_model rar_remote_model_i (.i_clk, .i_srst,
    .i_fwd_valid(o_fwd_valid), .o_fwd_ready(i_fwd_ready),
    .o_done(i_remote_done), .o_ack(i_remote_ack), .i_slow(slow),
    .i_ack(mack));

  always #12.5 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [33:0] s, x);
    compares++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic end_of_test();
    // Notes never matched by a result count as misses
    errors += q_apb.size() + q_rsp.size() + q_fwd.size();
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watches results and takes the oldest note for each
  always @(posedge i_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      e = q_apb.size() ? q_apb.pop_front() : 'x;
      chk("pslverr", 34'(o_pslverr), 34'(e[32]));
      if (e[33]) chk("prdata", 34'(o_prdata), 34'(e[31:0]));
    end
    if (o_rsp_valid === 1'b1) begin
      e = q_rsp.size() ? q_rsp.pop_front() : 'x;
      chk("rsp_ack", 34'(o_rsp_ack), e);
    end
    if (o_fwd_valid === 1'b1 && i_fwd_ready === 1'b1) begin
      e = q_fwd.size() ? q_fwd.pop_front() : 'x;
      chk("fwd", 34'(o_fwd), e);
    end
    cyc++;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Upper data bits are random: they must be ignored
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic [33:0] x);
    q_apb.push_back(x);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'($urandom), d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask

  function automatic logic [11:0] ra(input int k, input int n);
    return {2'h0, (k ? rar_pkg::MATCH_ADDR_SLOT0_IDX
      : rar_pkg::REMOTE_ADDR_SLOT5_IDX - 8'h05) + 8'(n), 2'h0};
  endfunction

  task automatic wr(input int k, input int n, input logic [7:0] d);
    mdl[k][n] = k ? d : {d[7:1], 1'b0};
    apb(1'b1, ra(k, n), d, 34'h0);
  endtask

  task automatic rd(input int k, input int n);
    apb(1'b0, ra(k, n), 8'h00, {2'h2, 24'h0, mdl[k][n]});
  endtask

  task automatic i2c(input logic [6:0] a, input logic w, lk, sl, ak);
    int hit = -1;
    for (int n = 7; n >= 0; n--)
      if (mdl[1][n][7:1] == a && a != 7'h00) hit = n;
    if (hit < 0) q_rsp.push_back(34'h0);
    else begin
      if (lk) q_fwd.push_back(34'({mdl[0][hit][7:1], w}));
      q_rsp.push_back(34'((mdl[1][hit][0] && w) || (lk && ak)));
    end
    i_fwd_lock <= lk;
    slow <= sl;
    mack <= ak;
    i_req_valid <= 1'b1;
    i_req <= '{addr: a, wr: w};
    do @(negedge i_clk); while (o_req_ready !== 1'b1);
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    do @(negedge i_clk); while (o_rsp_valid !== 1'b1);
    // Let a late remote answer drain before the next request
    repeat (14) @(posedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h49baf550));
    mdl = '{default: 8'h00};
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      rd(0, n);
      rd(1, n);
    end
    apb(1'b1, 12'h000, 8'hFF, 34'h100000000);
    apb(1'b0, 12'h000, 8'h00, 34'h300000000);
    apb(1'b0, ra(1, 0) + 12'h001, 8'h00, 34'h300000000);
    for (int n = 0; n < 8; n++) begin
      wr(0, n, 8'($urandom) | 8'h01);
      wr(1, n, {n[2:0], 4'($urandom) | 4'h1, 1'b0});
      rd(0, n);
      rd(1, n);
    end
    for (int i = 0; i < 24; i++) begin
      i2c(mdl[1][i % 8][7:1], i[3], 1'($urandom), 1'($urandom),
          1'($urandom));
      i2c({i[2:0], 4'h0}, i[0], 1'b1, 1'b0, 1'b1);
    end
    // Debug-only forced acknowledge on one slot
    wr(1, 2, mdl[1][2] | 8'h01);
    rd(1, 2);
    for (int i = 0; i < 4; i++)
      i2c(mdl[1][2][7:1], ~i[1], i[0], 1'b1, 1'b0);
    old = mdl[1][3][7:1];
    wr(1, 3, 8'h01);
    i2c(old, 1'b1, 1'b1, 1'b0, 1'b1);
    i2c(7'h00, 1'b1, 1'b1, 1'b0, 1'b1);
    // Lock drops while a forced write waits on the slow far side
    q_rsp.push_back(34'h1);
    slow <= 1'b1;
    i_fwd_lock <= 1'b1;
    i_req_valid <= 1'b1;
    i_req <= '{addr: mdl[1][2][7:1], wr: 1'b1};
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    @(posedge i_clk);
    i_fwd_lock <= 1'b0;
    repeat (14) @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    mdl = '{default: 8'h00};
    rd(1, 2);
    rd(0, 7);
    end_of_test();
  end
endmodule
